// ===== hw/pmbch_top.sv
// Purpose: PMBus command intake, busy handshake and partial fault log flagging
// Assumes: PMBus front end on i_core_clk holds a request until o_pmb_done
// Notes:   Avalon-MM slave for software registers
//
// Function
// - One buffer word per command, newest kept
// - Write buffers data, processor executes concurrently
// - Pending commands may execute out of order
// - Bit 5 clear while calculation pending
// - Handshake status read always valid
// - Busy: NACK or 0xFFFF, fault, alert, stretch
// - Stretch only if config bit 1, fast bus
// - Bit 6 clear while anything executes
// - Bit 4 clear while output ramps
// - Command after all flags set is accepted
// - Status bytes may disagree; host rereads
// - Partial log at power-up sets flags, stops logging
// - Log erase clears partial log, reenables logging
//
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "pmbch_params.svh"

module pmbch_top
  import pmbch_pkg::*;
(
  input  wire logic                     i_core_clk,
  input  wire logic                     i_rst_n,
  input  wire logic [4:0]               i_avs_address,
  input  wire logic                     i_avs_read,
  input  wire logic                     i_avs_write,
  input  wire logic [31:0]              i_avs_writedata,
  input  wire logic [3:0]               i_avs_byteenable,
  output logic      [31:0]              o_avs_readdata,
  output logic                          o_avs_waitrequest,
  input  wire logic                     i_pmb_wr,
  input  wire logic                     i_pmb_rd,
  input  wire logic [7:0]               i_pmb_cmd,
  input  wire logic [`PMBCH_DATA_W-1:0] i_pmb_wdata,
  input  wire logic                     i_pmb_fast,
  output logic                          o_pmb_done,
  output logic                          o_pmb_nack,
  output logic      [`PMBCH_DATA_W-1:0] o_pmb_rdata,
  output logic                          o_scl_stretch,
  output logic                          o_proc_valid,
  output logic      [`PMBCH_IDX_W-1:0]  o_proc_cmd,
  output logic      [`PMBCH_DATA_W-1:0] o_proc_data,
  input  wire logic                     i_proc_done,
  input  wire logic                     i_vout_ramp,
  input  wire logic                     i_partial_log_nv,
  output logic                          o_log_erase,
  output logic                          o_log_enable,
  input  wire logic                     i_alert_i,
  output logic                          o_alert_o,
  output logic                          o_alert_oe,
  output logic                          o_irq
);

  // ****************************************
  // State and decode
  // ****************************************
  pmbch_bus_st_t            bus_st_reg;
  pmbch_disp_st_t           disp_st_reg;
  logic [`PMBCH_DEPTH-1:0]  pend_reg;
  logic [`PMBCH_IDX_W-1:0]  disp_idx_reg;
  logic [`PMBCH_IDX_W-1:0]  pick_idx;
  logic [`PMBCH_IDX_W-1:0]  rd_idx;
  logic [`PMBCH_DATA_W-1:0] mem_rdata;
  logic                     hs_trans_reg;
  logic                     hs_calc_reg;
  logic                     hs_chip_reg;
  logic [7:0]               gcfg_reg;
  logic [1:0]               ctrl_reg;
  logic [`PMBCH_IRQ_W-1:0]  irq_st_reg;
  logic [`PMBCH_IRQ_W-1:0]  irq_mask_reg;
  logic                     partial_reg;
  logic                     cap_done_reg;
  logic                     alert_s1_reg;
  logic                     alert_s2_reg;
  logic                     ready_prev_reg;
  logic                     is_buf;
  logic                     busy;
  logic                     stretch_ok;
  logic                     idle_req;
  logic                     buf_take;
  logic                     busy_evt;
  logic                     erase_take;
  logic                     gcfg_take;
  logic                     calc_idle;
  logic                     av_wr;
  logic [`PMBCH_IRQ_W-1:0]  irq_set;
  logic [`PMBCH_IRQ_W-1:0]  irq_clr;
  logic [7:0]               hs_byte;

  assign is_buf     = (i_pmb_cmd[7:4] == `PMBCH_BUF_PAGE);
  assign busy       = !hs_chip_reg;
  assign stretch_ok = gcfg_reg[`PMBCH_GCFG_STRETCH] && i_pmb_fast;
  assign idle_req   = (bus_st_reg == B_IDLE) && (i_pmb_wr || i_pmb_rd);
  assign buf_take   = i_pmb_wr && is_buf &&
                      (((bus_st_reg == B_IDLE) && (!busy ||
                        (!stretch_ok && !ctrl_reg[`PMBCH_CTRL_NACK]))) ||
                       ((bus_st_reg == B_HOLD) && !busy));
  assign busy_evt   = idle_req && is_buf && busy && !stretch_ok;
  assign erase_take = (bus_st_reg == B_IDLE) && i_pmb_wr && (i_pmb_cmd == `PMBCH_CMD_ERASE);
  assign gcfg_take  = (bus_st_reg == B_IDLE) && i_pmb_wr && (i_pmb_cmd == `PMBCH_CMD_GCFG);
  assign calc_idle  = !(|pend_reg) && (disp_st_reg == D_IDLE);
  assign av_wr      = i_avs_write && !o_avs_waitrequest;
  assign hs_byte    = {1'b0, hs_chip_reg, hs_calc_reg, hs_trans_reg, 4'h0};
  assign rd_idx     = ((disp_st_reg == D_IDLE) && (|pend_reg)) ? pick_idx
                                                               : i_pmb_cmd[`PMBCH_IDX_W-1:0];

  // ****************************************
  // Command buffer
  // ****************************************
  pmbch_cmd_buf u_buf (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_we       (buf_take),
    .i_waddr    (i_pmb_cmd[`PMBCH_IDX_W-1:0]),
    .i_wdata    (i_pmb_wdata),
    .i_raddr    (rd_idx),
    .o_rdata    (mem_rdata)
  );

  // ****************************************
  // Pending marks and dispatch
  // ****************************************
  always_comb begin
    pick_idx = '0;
    for (int k = `PMBCH_DEPTH - 1; k >= 0; k--) begin
      if (pend_reg[k]) begin
        pick_idx = k[`PMBCH_IDX_W-1:0];
      end
    end
  end

  for (genvar g = 0; g < `PMBCH_DEPTH; g++) begin : g_pend
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        pend_reg[g] <= 1'b0;
      end else if (buf_take && (i_pmb_cmd[`PMBCH_IDX_W-1:0] == g)) begin
        pend_reg[g] <= 1'b1;
      end else if ((disp_st_reg == D_IDLE) && (|pend_reg) && (pick_idx == g)) begin
        pend_reg[g] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      disp_st_reg  <= D_IDLE;
      disp_idx_reg <= '0;
      o_proc_valid <= 1'b0;
      o_proc_cmd   <= '0;
      o_proc_data  <= 16'h0000;
    end else begin
      o_proc_valid <= 1'b0;
      case (disp_st_reg)
        D_IDLE: begin
          if (|pend_reg) begin
            disp_idx_reg <= pick_idx;
            disp_st_reg  <= D_FETCH;
          end
        end
        D_FETCH: begin
          o_proc_valid <= 1'b1;
          o_proc_cmd   <= disp_idx_reg;
          o_proc_data  <= mem_rdata;
          disp_st_reg  <= D_RUN;
        end
        D_RUN: begin
          if (i_proc_done) begin
            disp_st_reg <= D_IDLE;
          end
        end
        default: begin
          disp_st_reg <= D_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Handshake flags
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hs_trans_reg <= 1'b0;
      hs_calc_reg  <= 1'b0;
      hs_chip_reg  <= 1'b0;
    end else begin
      hs_trans_reg <= !i_vout_ramp;
      hs_calc_reg  <= calc_idle;
      hs_chip_reg  <= calc_idle && !i_vout_ramp;
    end
  end

  // ****************************************
  // PMBus transaction answer
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_st_reg    <= B_IDLE;
      o_pmb_done    <= 1'b0;
      o_pmb_nack    <= 1'b0;
      o_pmb_rdata   <= 16'h0000;
      o_scl_stretch <= 1'b0;
    end else begin
      o_pmb_done <= 1'b0;
      case (bus_st_reg)
        B_IDLE: begin
          o_pmb_nack <= 1'b0;
          if (idle_req && is_buf && busy && stretch_ok) begin
            o_scl_stretch <= 1'b1;
            bus_st_reg    <= B_HOLD;
          end else if (idle_req && is_buf && i_pmb_rd && !busy) begin
            bus_st_reg <= B_RD;
          end else if (idle_req) begin
            o_pmb_done <= 1'b1;
            bus_st_reg <= B_ACK;
            if (i_pmb_rd && is_buf) begin
              o_pmb_rdata <= `PMBCH_BUSY_DATA;
            end else if (i_pmb_rd && (i_pmb_cmd == `PMBCH_CMD_HS)) begin
              o_pmb_rdata <= {hs_byte, hs_byte};
            end else if (i_pmb_rd && (i_pmb_cmd == `PMBCH_CMD_GCFG)) begin
              o_pmb_rdata <= {8'h00, gcfg_reg};
            end else if (i_pmb_rd && (i_pmb_cmd == `PMBCH_CMD_VSTAT)) begin
              o_pmb_rdata <= {8'h00, 4'h0, partial_reg, 3'h0};
            end else if (i_pmb_rd && (i_pmb_cmd == `PMBCH_CMD_CSTAT)) begin
              o_pmb_rdata <= {8'h00, 3'h0, partial_reg, 4'h0};
            end else if (i_pmb_rd) begin
              o_pmb_nack <= 1'b1;
            end else if (is_buf) begin
              o_pmb_nack <= !buf_take;
            end else begin
              o_pmb_nack <= !(erase_take || gcfg_take);
            end
          end
        end
        B_HOLD: begin
          if (!busy) begin
            o_scl_stretch <= 1'b0;
            if (i_pmb_rd) begin
              bus_st_reg <= B_RD;
            end else begin
              o_pmb_done <= 1'b1;
              bus_st_reg <= B_ACK;
            end
          end
        end
        B_RD: begin
          o_pmb_rdata <= mem_rdata;
          o_pmb_done  <= 1'b1;
          bus_st_reg  <= B_ACK;
        end
        B_ACK: begin
          bus_st_reg <= B_IDLE;
        end
        default: begin
          bus_st_reg <= B_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Fault log partial flag
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cap_done_reg <= 1'b0;
      partial_reg  <= 1'b0;
      o_log_erase  <= 1'b0;
      o_log_enable <= 1'b0;
    end else begin
      cap_done_reg <= 1'b1;
      o_log_erase  <= erase_take;
      if (!cap_done_reg && i_partial_log_nv) begin
        partial_reg <= 1'b1;
      end else if (erase_take) begin
        partial_reg <= 1'b0;
      end
      o_log_enable <= gcfg_reg[`PMBCH_GCFG_LOG] && !partial_reg && !erase_take &&
                      cap_done_reg;
    end
  end

  // ****************************************
  // Avalon-MM slave and registers
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
    end else if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b0;
      o_avs_readdata    <= 32'h0000_0000;
      if (i_avs_address == `PMBCH_AV_IRQ_ST) begin
        o_avs_readdata[`PMBCH_IRQ_W-1:0] <= irq_st_reg;
      end else if (i_avs_address == `PMBCH_AV_IRQ_MASK) begin
        o_avs_readdata[`PMBCH_IRQ_W-1:0] <= irq_mask_reg;
      end else if (i_avs_address == `PMBCH_AV_HS_STATUS) begin
        o_avs_readdata[7:0] <= hs_byte;
      end else if (i_avs_address == `PMBCH_AV_GCFG) begin
        o_avs_readdata[7:0] <= gcfg_reg;
      end else if (i_avs_address == `PMBCH_AV_CTRL) begin
        o_avs_readdata[2:0] <= {alert_s2_reg, ctrl_reg};
      end
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gcfg_reg     <= `PMBCH_GCFG_RST;
      ctrl_reg     <= `PMBCH_CTRL_RST;
      irq_mask_reg <= '0;
    end else begin
      if (gcfg_take) begin
        gcfg_reg <= i_pmb_wdata[7:0];
      end else if (av_wr && i_avs_byteenable[0] && (i_avs_address == `PMBCH_AV_GCFG)) begin
        gcfg_reg <= i_avs_writedata[7:0];
      end
      if (av_wr && i_avs_byteenable[0] && (i_avs_address == `PMBCH_AV_CTRL)) begin
        ctrl_reg <= i_avs_writedata[1:0];
      end
      if (av_wr && i_avs_byteenable[0] && (i_avs_address == `PMBCH_AV_IRQ_MASK)) begin
        irq_mask_reg <= i_avs_writedata[`PMBCH_IRQ_W-1:0];
      end
    end
  end

  // ****************************************
  // Interrupt, alert pin
  // ****************************************
  assign irq_set = {hs_chip_reg && hs_calc_reg && hs_trans_reg && !ready_prev_reg,
                    !cap_done_reg && i_partial_log_nv,
                    busy_evt};
  assign irq_clr = (av_wr && i_avs_byteenable[0] && (i_avs_address == `PMBCH_AV_IRQ_ST)) ?
                   i_avs_writedata[`PMBCH_IRQ_W-1:0] : '0;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_st_reg     <= '0;
      ready_prev_reg <= 1'b0;
      o_irq          <= 1'b0;
      o_alert_o      <= 1'b0;
      o_alert_oe     <= 1'b0;
      alert_s1_reg   <= 1'b1;
      alert_s2_reg   <= 1'b1;
    end else begin
      irq_st_reg     <= (irq_st_reg & ~irq_clr) | irq_set;
      ready_prev_reg <= hs_chip_reg && hs_calc_reg && hs_trans_reg;
      o_irq          <= |(irq_st_reg & irq_mask_reg);
      o_alert_o      <= 1'b0;
      o_alert_oe     <= irq_st_reg[`PMBCH_IRQ_BUSY] && ctrl_reg[`PMBCH_CTRL_ALERT];
      alert_s1_reg   <= i_alert_i;
      alert_s2_reg   <= alert_s1_reg;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_disp_pick;
    (disp_st_reg == D_IDLE) && (|pend_reg) ##1 (disp_st_reg == D_FETCH);
  endsequence

  sequence s_ready_write;
    (bus_st_reg == B_IDLE) && i_pmb_wr && is_buf && hs_chip_reg;
  endsequence

  property p_calc_flag;
    @(posedge i_core_clk) disable iff (!i_rst_n) (|pend_reg) |=> !hs_calc_reg;
  endproperty
  a_calc_flag: assert property (p_calc_flag) else $error("calc flag set while pending");

  property p_chip_flag;
    @(posedge i_core_clk) disable iff (!i_rst_n) (disp_st_reg == D_RUN) |=> !hs_chip_reg;
  endproperty
  a_chip_flag: assert property (p_chip_flag) else $error("chip flag set while running");

  property p_trans_flag;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_vout_ramp |=> !hs_trans_reg && !hs_chip_reg;
  endproperty
  a_trans_flag: assert property (p_trans_flag) else $error("flags set during ramp");

  property p_newest_kept;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      buf_take |=> pend_reg[$past(i_pmb_cmd[`PMBCH_IDX_W-1:0])] || (disp_st_reg == D_FETCH);
  endproperty
  a_newest_kept: assert property (p_newest_kept) else $error("write lost");

  property p_dispatch;
    @(posedge i_core_clk) disable iff (!i_rst_n) s_disp_pick |=> o_proc_valid;
  endproperty
  a_dispatch: assert property (p_dispatch) else $error("no dispatch");

  property p_ready_accept;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      s_ready_write |=> o_pmb_done && !o_pmb_nack && !o_scl_stretch;
  endproperty
  a_ready_accept: assert property (p_ready_accept) else $error("ready write refused");

  property p_busy_ones;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      idle_req && i_pmb_rd && is_buf && busy && !stretch_ok |=>
      o_pmb_done && (o_pmb_rdata == `PMBCH_BUSY_DATA) ##1 irq_st_reg[`PMBCH_IRQ_BUSY];
  endproperty
  a_busy_ones: assert property (p_busy_ones) else $error("busy read not all ones");

  property p_stretch_gate;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(o_scl_stretch) |-> $past(gcfg_reg[`PMBCH_GCFG_STRETCH] && i_pmb_fast);
  endproperty
  a_stretch_gate: assert property (p_stretch_gate) else $error("stretch not enabled");

  property p_hs_read;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      idle_req && i_pmb_rd && (i_pmb_cmd == `PMBCH_CMD_HS) |=>
      o_pmb_done && !o_pmb_nack && (o_pmb_rdata[7:0] == $past(hs_byte));
  endproperty
  a_hs_read: assert property (p_hs_read) else $error("status read invalid");

  property p_erase;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      erase_take && cap_done_reg |=> !partial_reg ##1 (o_log_enable == gcfg_reg[7]);
  endproperty
  a_erase: assert property (p_erase) else $error("erase failed");

  property p_partial;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      !cap_done_reg && i_partial_log_nv |=> partial_reg [*2] ##0 !o_log_enable;
  endproperty
  a_partial: assert property (p_partial) else $error("partial log not flagged");

endmodule : pmbch_top

// ===== include/pmbch_params.svh
// Purpose: Offsets, field positions, command codes and reset values of the handshake block
// Assumes: Included by design files and the testbench
// Notes:   Byte addresses on the register bus
`ifndef PMBCH_PARAMS_SVH
`define PMBCH_PARAMS_SVH

// ****************************************
// Register bus offsets
// ****************************************
`define PMBCH_AV_IRQ_ST     5'h00
`define PMBCH_AV_IRQ_MASK   5'h04
`define PMBCH_AV_HS_STATUS  5'h08
`define PMBCH_AV_GCFG       5'h0C
`define PMBCH_AV_CTRL       5'h10

// ****************************************
// PMBus command codes
// ****************************************
`define PMBCH_CMD_HS        8'hE0
`define PMBCH_CMD_GCFG      8'hD0
`define PMBCH_CMD_ERASE     8'hE1
`define PMBCH_CMD_VSTAT     8'h80
`define PMBCH_CMD_CSTAT     8'h81
`define PMBCH_BUF_PAGE      4'h0

// ****************************************
// Field positions
// ****************************************
`define PMBCH_HS_TRANS      4
`define PMBCH_HS_CALC       5
`define PMBCH_HS_CHIP       6
`define PMBCH_GCFG_STRETCH  1
`define PMBCH_GCFG_LOG      7
`define PMBCH_VSTAT_PART    3
`define PMBCH_CSTAT_PART    4
`define PMBCH_IRQ_BUSY      0
`define PMBCH_IRQ_PART      1
`define PMBCH_IRQ_READY     2
`define PMBCH_CTRL_NACK     0
`define PMBCH_CTRL_ALERT    1
`define PMBCH_CTRL_PIN      2

// ****************************************
// Sizes and reset values
// ****************************************
`define PMBCH_DEPTH         16
`define PMBCH_IDX_W         4
`define PMBCH_DATA_W        16
`define PMBCH_IRQ_W         3
`define PMBCH_GCFG_RST      8'h00
`define PMBCH_CTRL_RST      2'h1
`define PMBCH_BUSY_DATA     16'hFFFF

`endif

// ===== include/pmbch_pkg.sv
// Purpose: Types of the handshake block
// Assumes: None
// Notes:   One-hot state codes
package pmbch_pkg;

  // ****************************************
  // State types
  // ****************************************
  typedef enum logic [3:0] {
    B_IDLE = 4'b0001,
    B_HOLD = 4'b0010,
    B_RD   = 4'b0100,
    B_ACK  = 4'b1000
  } pmbch_bus_st_t;

  typedef enum logic [2:0] {
    D_IDLE  = 3'b001,
    D_FETCH = 3'b010,
    D_RUN   = 3'b100
  } pmbch_disp_st_t;

endpackage : pmbch_pkg

// ===== hw/pmbch_cmd_buf.sv
// Purpose: One data word per supported command, registered read
// Assumes: Single clock
// Notes:   Write overwrites the older word
`timescale 1ns/1ns
`include "pmbch_params.svh"

module pmbch_cmd_buf (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_we,
  input  wire logic [`PMBCH_IDX_W-1:0]  i_waddr,
  input  wire logic [`PMBCH_DATA_W-1:0] i_wdata,
  input  wire logic [`PMBCH_IDX_W-1:0]  i_raddr,
  output logic      [`PMBCH_DATA_W-1:0] o_rdata
);

  logic [`PMBCH_DATA_W-1:0] mem [`PMBCH_DEPTH];

  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule : pmbch_cmd_buf

// ===== verif/pmbch_host_model.sv
// Purpose: PMBus host front end model, one transaction at a time
// Assumes: Requests taken at the rising edge of i_core_clk
// Notes:   Records whether SCL was stretched during the last transfer
`timescale 1ns/1ns

module pmbch_host_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_done,
  input  wire logic        i_nack,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_stretch,
  output logic             o_wr,
  output logic             o_rd,
  output logic [7:0]       o_cmd,
  output logic [15:0]      o_wdata
);
  logic saw_stretch = 1'b0;
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_cmd = 8'h00;
    o_wdata = 16'h0000;
  end
  // Request held until done, waits on stretch, then a spare cycle
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic nack, output logic [15:0] rd);
    saw_stretch = 1'b0;
    @(posedge i_core_clk);
    o_wr <= w; o_rd <= !w; o_cmd <= c; o_wdata <= d;
    do begin
      @(posedge i_core_clk);
      if (i_stretch === 1'b1) saw_stretch = 1'b1;
    end while (i_done !== 1'b1);
    nack = i_nack;
    rd = i_rdata;
    o_wr <= 1'b0; o_rd <= 1'b0; o_wdata <= ~d;
    @(posedge i_core_clk);
  endtask : xfer
endmodule : pmbch_host_model

// ===== verif/pmbus_command_handshake_tb.sv
// Purpose: Self-checking bench of the handshake block
// Assumes: Processor and fault log memory modelled here
// Notes:   Avalon master and PMBus host wait on handshakes
`timescale 1ns/1ns
`include "pmbch_params.svh"

module pmbus_command_handshake_tb;
  logic clk = 1'b0, rst_n = 1'b0, a_rd = 1'b0, a_wr = 1'b0, fast = 1'b0, pdone = 1'b0;
  logic ramp = 1'b0, part = 1'b0, a_wait, wr, rd, done, nack, stretch, pvalid, erase;
  logic log_en, alert_o, alert_oe, irq, ack;
  logic [4:0] a_addr = 5'h00;
  logic [31:0] a_wd = 32'h0000_0000, a_rdata, rv;
  logic [7:0] cmd;
  logic [15:0] wd, rdat, pdata, r;
  logic [3:0] pcmd;
  logic [19:0] pq[$];
  int n_errors = 0, n_checks = 0, cyc = 0, plat = 60;
  always #5 clk = ~clk;
  pmbch_top dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_avs_address(a_addr), .i_avs_read(a_rd),
    .i_avs_write(a_wr), .i_avs_writedata(a_wd), .i_avs_byteenable(4'h1), .o_avs_readdata(a_rdata),
    .o_avs_waitrequest(a_wait), .i_pmb_wr(wr), .i_pmb_rd(rd), .i_pmb_cmd(cmd), .i_pmb_wdata(wd),
    .i_pmb_fast(fast), .o_pmb_done(done), .o_pmb_nack(nack), .o_pmb_rdata(rdat),
    .o_scl_stretch(stretch), .o_proc_valid(pvalid), .o_proc_cmd(pcmd), .o_proc_data(pdata),
    .i_proc_done(pdone), .i_vout_ramp(ramp), .i_partial_log_nv(part), .o_log_erase(erase),
    .o_log_enable(log_en), .i_alert_i(!alert_oe), .o_alert_o(alert_o), .o_alert_oe(alert_oe),
    .o_irq(irq));
  pmbch_host_model host (.i_core_clk(clk), .i_done(done), .i_nack(nack), .i_rdata(rdat),
    .i_stretch(stretch), .o_wr(wr), .o_rd(rd), .o_cmd(cmd), .o_wdata(wd));
  // Processor: logs each command, ends it after plat cycles
  always @(posedge clk) begin
    if (pvalid === 1'b1) begin
      pq.push_back({pcmd, pdata});
      repeat (plat) @(posedge clk);
      pdone <= 1'b1;
      @(posedge clk);
      pdone <= 1'b0;
    end
  end
  always @(posedge clk) if (erase === 1'b1) part <= 1'b0;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic av(input logic w, input logic [4:0] ad, input logic [31:0] d);
    @(posedge clk);
    a_addr <= ad; a_wr <= w; a_rd <= !w; a_wd <= d;
    do begin
      @(posedge clk);
    end while (a_wait !== 1'b0);
    rv = a_rdata;
    a_wr <= 1'b0; a_rd <= 1'b0; a_wd <= ~d;
  endtask : av
  task automatic pm(input logic w, input logic [7:0] c, input logic [15:0] d);
    host.xfer(w, c, d, ack, r);
  endtask : pm
  task automatic poll_ready;
    do begin
      pm(0, `PMBCH_CMD_HS, 16'h0);
    end while (r !== 16'h7070);
  endtask : poll_ready
  task automatic do_reset(input logic p);
    part <= p;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : do_reset
  task automatic t_regs;
    av(0, `PMBCH_AV_IRQ_MASK, 32'h0); chk(rv[15:0], 16'h0000);
    av(0, `PMBCH_AV_HS_STATUS, 32'h0); chk(rv[15:0], 16'h0070);
    av(1, 5'h14, 32'hFFFF_FFFF);
    av(0, 5'h14, 32'h0); chk(rv[15:0], 16'h0000);
    av(0, `PMBCH_AV_GCFG, 32'h0); chk(rv[15:0], 16'h0000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_buf;
    av(1, `PMBCH_AV_CTRL, 32'h0);
    pm(1, 8'h03, 16'h1111); chk(ack, 1'b0);
    pm(0, `PMBCH_CMD_HS, 16'h0); chk(r, 16'h1010);
    pm(1, 8'h07, 16'h7777);
    pm(1, 8'h05, 16'h5555);
    pm(1, 8'h05, 16'h5A5A); chk(ack, 1'b0);
    pm(0, 8'h05, 16'h0); chk(r, 16'hFFFF);
    av(0, `PMBCH_AV_IRQ_ST, 32'h0); chk(rv[0], 1'b1);
    av(1, `PMBCH_AV_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk); chk(irq, 1'b1);
    av(1, `PMBCH_AV_IRQ_ST, 32'h1);
    repeat (2) @(posedge clk); chk(irq, 1'b0);
    repeat (250) @(posedge clk);
    chk(20'(pq.size()), 20'h3);
    chk(pq[0], 20'h3_1111);
    chk(pq[1], 20'h5_5A5A);
    chk(pq[2], 20'h7_7777);
    $display("test buffer done");
  endtask : t_buf
  task automatic t_busy;
    av(1, `PMBCH_AV_CTRL, 32'h3);
    poll_ready();
    pm(1, 8'h02, 16'h2222); chk(ack, 1'b0);
    pm(1, 8'h02, 16'h2323); chk(ack, 1'b1);
    chk(alert_oe, 1'b1);
    chk(alert_o, 1'b0);
    av(0, `PMBCH_AV_CTRL, 32'h0); chk(rv[2:0], 3'h3);
    fast <= 1'b1;
    pm(1, 8'h02, 16'h2424); chk(host.saw_stretch, 1'b0);
    av(1, `PMBCH_AV_GCFG, 32'h2);
    pm(1, 8'h02, 16'h2525); chk(host.saw_stretch, 1'b1);
    chk(ack, 1'b0);
    fast <= 1'b0;
    repeat (150) @(posedge clk);
    $display("test busy done");
  endtask : t_busy
  task automatic t_ramp;
    ramp <= 1'b1;
    repeat (3) @(posedge clk);
    pm(0, `PMBCH_CMD_HS, 16'h0); chk(r, 16'h2020);
    ramp <= 1'b0;
    repeat (3) @(posedge clk);
    pm(0, `PMBCH_CMD_HS, 16'h0); chk(r, 16'h7070);
    $display("test ramp done");
  endtask : t_ramp
  task automatic t_log;
    do_reset(1'b1);
    av(1, `PMBCH_AV_GCFG, 32'h80);
    repeat (2) @(posedge clk); chk(log_en, 1'b0);
    pm(0, `PMBCH_CMD_VSTAT, 16'h0); chk(r[3], 1'b1);
    pm(0, `PMBCH_CMD_CSTAT, 16'h0); chk(r[4], 1'b1);
    pm(1, `PMBCH_CMD_ERASE, 16'h0);
    repeat (3) @(posedge clk); chk(log_en, 1'b1);
    chk(part, 1'b0);
    pm(0, `PMBCH_CMD_VSTAT, 16'h0); chk(r[3], 1'b0);
    $display("test log done");
  endtask : t_log
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    do_reset(1'b0);
    t_regs();
    t_buf();
    t_busy();
    t_ramp();
    t_log();
    print_verdict();
  end
endmodule : pmbus_command_handshake_tb
